// >>> tss_pkg.sv
// Shared constants and types of the time-slot switch
package tss_pkg;

    // ----------------------------------------------------------------
    // Stream geometry
    // ----------------------------------------------------------------
    localparam int STREAMS = 8;
    localparam int CHANS = 32;
    localparam int BYTE_W = 8;
    localparam int MEM_WORDS = STREAMS * CHANS;
    localparam int FRAME_US = 125;
    localparam int BIT_RATE_KBPS = 2048;
    localparam int BITS_PER_FRAME = BIT_RATE_KBPS * FRAME_US / 1000;
    localparam int C4_PER_BIT = 2;
    localparam int CNT_W = $clog2(BITS_PER_FRAME * C4_PER_BIT);
    localparam logic [CNT_W-1:0] CNT_ONE = 9'h001;
    localparam logic [3:0] SLOT_FIRST = 4'h0;
    localparam logic [3:0] SLOT_LAST = 4'hF;
    localparam logic [4:0] CHAN_ONE = 5'h01;
    localparam logic [3:0] RX_PUSHES = 4'h8;

    // ----------------------------------------------------------------
    // Processor port timing
    // ----------------------------------------------------------------
    localparam int SYS_CLK_MHZ = 50;
    localparam int CPU_FAST_NS = 20;
    localparam int CPU_SLOW_NS = 100;
    localparam int CPU_FAST_CYC = (CPU_FAST_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int CPU_SLOW_CYC = (CPU_SLOW_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam logic [2:0] WAIT_FAST = 3'(CPU_FAST_CYC - 1);
    localparam logic [2:0] WAIT_SLOW = 3'(CPU_SLOW_CYC - 1);
    localparam logic [2:0] WAIT_DONE = 3'h0;
    localparam int ADDR_MEM_BIT = 5;

    // ----------------------------------------------------------------
    // Register layouts
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        MS_RSVD = 2'b00,
        MS_DATA = 2'b01,
        MS_CML = 2'b10,
        MS_CMH = 2'b11
    } tss_memsel_t;

    typedef struct packed {
        logic split;
        logic msgAll;
        logic unused;
        tss_memsel_t memSel;
        logic [2:0] stream;
    } tss_ctrl_t;

    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CTRL_RD_MASK = 8'hDF;

    // Output channel control entry, bits 2..0
    typedef struct packed {
        logic msg;
        logic cst;
        logic enable;
    } tss_cmh_t;

    // Low entry read as a switch source
    typedef struct packed {
        logic [2:0] stream;
        logic [4:0] chan;
    } tss_cml_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } tss_rxword_t;

    localparam int FIFO_DEPTH = 8;

    typedef enum logic [1:0] {
        CPU_IDLE = 2'b00,
        CPU_WAIT = 2'b01,
        CPU_ACK = 2'b10
    } tss_cpu_t;

    // Pins that arrive from outside the clock domain
    typedef struct packed {
        logic c4n;
        logic frameN;
        logic output_drive_enable;
        logic csN;
        logic ds;
        logic rw;
        logic [5:0] addr;
        logic [7:0] din;
        logic [7:0] serIn;
    } tss_pins_t;

endpackage

// >>> tss_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module tss_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Fill side
    input wire logic inVld,
    output logic inRdy,
    input wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic outVld,
    input wire logic outRdy,
    output logic [WIDTH-1:0] outData
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wr;
        logic [PW-1:0] rd;
        logic [CW-1:0] count;
    } tss_fifo_st_t;

    tss_fifo_st_t st;
    tss_fifo_st_t next_st;
    logic push;
    logic pop;

    // Honest flags straight from the count
    assign inRdy = (st.count != CW'(DEPTH));
    assign outVld = (st.count != '0);
    assign outData = st.mem[st.rd];
    assign push = inVld && inRdy;
    assign pop = outVld && outRdy;

    // Pointer and count update
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wr] = inData;
            next_st.wr = (st.wr == PW'(DEPTH - 1)) ? '0 : PW'(st.wr + 1'b1);
        end
        if (pop) begin
            next_st.rd = (st.rd == PW'(DEPTH - 1)) ? '0 : PW'(st.rd + 1'b1);
        end
        if (push && !pop) begin
            next_st.count = CW'(st.count + 1'b1);
        end else if (pop && !push) begin
            next_st.count = CW'(st.count - 1'b1);
        end
        if (!rst_n) begin
            next_st = '0;
        end
    end

    always_ff @(posedge clk_sys) begin
        st <= next_st;
    end
endmodule // tss_fifo
`default_nettype wire

// >>> tss_switch.sv
// Time-slot switch: serial framing, switch memories and processor port
//
// Functional notes
// RULE_01: Streams run at 2048 kbit/s in 125 us frames of 32 byte channels.
// RULE_02: Each received byte is stored at its stream/channel slot of data memory.
// RULE_03: Switched channel sends the data byte addressed by its low entry.
// RULE_04: Message channel sends its low entry byte, repeated every frame.
// RULE_05: Address bit 5 low always reaches the control register.
// RULE_06: Address bit 5 high picks channel 0..31 of selected memory and stream.
// RULE_07: Control bit 7 splits: reads from data memory, writes to low memory.
// RULE_08: Control bit 6 forces message and enable bits on for every channel.
// RULE_09: Control bits 4-3 select memory: reserved, data, low, high.
// RULE_10: Control bits 2-0 give the stream whose slice is in the window.
// RULE_11: High entry bit 2 chooses message (1) or switched (0) operation.
// RULE_12: Drive enable pin low makes every serial output high-impedance.
// RULE_13: Drive enable high with control bit 6 set drives all outputs.
// RULE_14: Otherwise high entry bit 0 enables that channel's output driver.
// RULE_15: High entry bit 1 goes out one channel early, stream 0 first.
// RULE_16: Control register write completes fast; other accesses are slow.
// RULE_17: All serial timing comes from the inverted clock and frame pulse.
// RULE_18: Low entry holds source stream in bits 7-5, channel in bits 4-0.
// RULE_19: Processor holds its access until acknowledge, then ends it.
`timescale 1ns/1ps
`default_nettype none
module tss_switch (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Serial timing
    input wire logic bitTimingClockInN,
    input wire logic framePulseInN,
    // Serial streams
    input wire logic [7:0] serialInLine,
    output logic [7:0] serialOutLine,
    output logic [7:0] serialOutLineEn,
    input wire logic outputDriveEnable,
    output logic controlStreamOut,
    // Processor port
    input wire logic chipSelectN,
    input wire logic readWrite,
    input wire logic dataStrobe,
    input wire logic [5:0] address,
    input wire logic [7:0] dataIn,
    output logic [7:0] dataOut,
    output logic dataOe,
    output logic dataAcknowledgeN
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        tss_pkg::tss_pins_t s1;
        tss_pkg::tss_pins_t s2;
        logic c4Prev;
        logic [tss_pkg::CNT_W-1:0] cnt;
        logic [7:0][7:0] rxShift;
        logic [7:0][7:0] rxHold;
        logic [4:0] rxChan;
        logic [3:0] rxPend;
        logic [7:0][7:0] txShift;
        logic [7:0] txEn;
        logic [7:0] serOut;
        logic [7:0] serOutEn;
        logic [7:0] cstShift;
        logic cstOut;
        tss_pkg::tss_ctrl_t ctrl;
        logic [tss_pkg::MEM_WORDS-1:0][7:0] dm;
        logic [tss_pkg::MEM_WORDS-1:0][7:0] cml;
        tss_pkg::tss_cmh_t [tss_pkg::MEM_WORDS-1:0] cmh;
        tss_pkg::tss_cpu_t cpu;
        logic [2:0] waitCnt;
        logic [7:0] dout;
        logic doe;
        logic ackN;
    } tss_state_t;

    tss_state_t st;
    tss_state_t next_st;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Memory slot of a stream and channel
    function automatic logic [7:0] memIdx(input logic [2:0] s, input logic [4:0] c);
        return {s, c};
    endfunction

    // ----------------------------------------------------------------
    // Receive buffer between framing and data memory
    // ----------------------------------------------------------------
    tss_pkg::tss_rxword_t pushWord;
    tss_pkg::tss_rxword_t popWord;
    logic pushVld;
    logic pushRdy;
    logic popVld;
    logic popRdy;
    logic [2:0] pushStream;
    logic cpuDmRead;

    assign pushVld = (st.rxPend != 4'h0);
    assign pushStream = 3'(tss_pkg::RX_PUSHES - st.rxPend);
    assign pushWord.addr = memIdx(pushStream, st.rxChan);
    assign pushWord.data = st.rxHold[pushStream];

    // A finishing data memory read owns the array for that cycle
    assign cpuDmRead = (st.cpu == tss_pkg::CPU_WAIT) && (st.waitCnt == tss_pkg::WAIT_DONE)
        && st.s2.rw && st.s2.addr[tss_pkg::ADDR_MEM_BIT]
        && (st.ctrl.split || st.ctrl.memSel == tss_pkg::MS_DATA);
    assign popRdy = !cpuDmRead;

    tss_fifo #(
        .WIDTH($bits(tss_pkg::tss_rxword_t)),
        .DEPTH(tss_pkg::FIFO_DEPTH)
    ) rxFifo (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .inVld(pushVld),
        .inRdy(pushRdy),
        .inData(pushWord),
        .outVld(popVld),
        .outRdy(popRdy),
        .outData(popWord)
    );

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        logic c4Edge;
        logic [4:0] ch;
        logic [4:0] chNext;
        logic [7:0] idx;
        logic msgEff;
        tss_pkg::tss_cml_t src;
        tss_pkg::tss_cmh_t ent;
        logic [7:0] winIdx;

        c4Edge = 1'b0;
        ch = '0;
        chNext = '0;
        idx = '0;
        msgEff = 1'b0;
        src = '0;
        ent = '0;
        winIdx = '0;
        next_st = st;

        // Two-stage pin synchronisers
        next_st.s1.c4n = bitTimingClockInN;
        next_st.s1.frameN = framePulseInN;
        next_st.s1.output_drive_enable = outputDriveEnable;
        next_st.s1.csN = chipSelectN;
        next_st.s1.ds = dataStrobe;
        next_st.s1.rw = readWrite;
        next_st.s1.addr = address;
        next_st.s1.din = dataIn;
        next_st.s1.serIn = serialInLine;
        next_st.s2 = st.s1;
        next_st.c4Prev = st.s2.c4n;

        // Falling edge of the bit clock is a rise of the inverted pin
        c4Edge = st.s2.c4n && !st.c4Prev; // [RULE_17]

        // Frame counter: two clock periods per bit, 256 bits per frame
        if (c4Edge) begin
            if (!st.s2.frameN) begin
                next_st.cnt = '0; // [RULE_17]
            end else begin
                next_st.cnt = tss_pkg::CNT_W'(st.cnt + tss_pkg::CNT_ONE); // [RULE_01]
            end
        end
        ch = next_st.cnt[8:4];
        chNext = 5'(ch + tss_pkg::CHAN_ONE);

        // Receive: sample late in each bit cell
        if (c4Edge && next_st.cnt[0]) begin
            for (int s = 0; s < tss_pkg::STREAMS; s++) begin
                next_st.rxShift[s] = {st.rxShift[s][6:0], st.s2.serIn[s]};
            end
            if (next_st.cnt[3:0] == tss_pkg::SLOT_LAST) begin
                next_st.rxHold = next_st.rxShift;
                next_st.rxChan = ch;
                next_st.rxPend = tss_pkg::RX_PUSHES; // [RULE_02]
            end
        end

        // Queue the eight bytes one per cycle; a full buffer stalls here
        if (pushVld && pushRdy) begin
            next_st.rxPend = 4'(st.rxPend - 1'b1);
        end

        // Drain into data memory at the byte's stream/channel slot
        if (popVld && popRdy) begin
            next_st.dm[popWord.addr] = popWord.data; // [RULE_02]
        end

        // Transmit: new bit at the start of each cell
        if (c4Edge && !next_st.cnt[0]) begin
            if (next_st.cnt[3:0] == tss_pkg::SLOT_FIRST) begin
                for (int s = 0; s < tss_pkg::STREAMS; s++) begin
                    idx = memIdx(3'(s), ch);
                    ent = st.cmh[idx];
                    src = st.cml[idx];
                    msgEff = st.ctrl.msgAll || ent.msg; // [RULE_08] [RULE_11]
                    if (msgEff) begin
                        next_st.txShift[s] = st.cml[idx]; // [RULE_04]
                    end else begin
                        // Switched byte from the named source slot
                        next_st.txShift[s] = st.dm[memIdx(src.stream, src.chan)]; // [RULE_03] [RULE_18]
                    end
                    next_st.txEn[s] = st.ctrl.msgAll || ent.enable; // [RULE_13] [RULE_14]
                    // Next channel's bits, stream 0 in the first slot
                    next_st.cstShift[7 - s] = st.cmh[memIdx(3'(s), chNext)].cst; // [RULE_15]
                end
            end else begin
                for (int s = 0; s < tss_pkg::STREAMS; s++) begin
                    next_st.txShift[s] = {st.txShift[s][6:0], 1'b0};
                end
                next_st.cstShift = {st.cstShift[6:0], 1'b0}; // [RULE_15]
            end
            for (int s = 0; s < tss_pkg::STREAMS; s++) begin
                next_st.serOut[s] = next_st.txShift[s][7];
            end
            next_st.cstOut = next_st.cstShift[7];
        end

        // Drivers follow the pin every cycle so a low pin frees the lines at once
        next_st.serOutEn = st.s2.output_drive_enable ? st.txEn : 8'h00; // [RULE_12]

        // ------------------------------------------------------------
        // Processor port
        // ------------------------------------------------------------
        winIdx = memIdx(st.ctrl.stream, st.s2.addr[4:0]); // [RULE_06] [RULE_10]
        case (st.cpu)
            tss_pkg::CPU_IDLE: begin
                if (!st.s2.csN && st.s2.ds) begin
                    next_st.cpu = tss_pkg::CPU_WAIT;
                    // Control register write is the only quick answer
                    if (!st.s2.addr[tss_pkg::ADDR_MEM_BIT] && !st.s2.rw) begin
                        next_st.waitCnt = tss_pkg::WAIT_FAST; // [RULE_16]
                    end else begin
                        next_st.waitCnt = tss_pkg::WAIT_SLOW; // [RULE_16]
                    end
                end
            end
            tss_pkg::CPU_WAIT: begin
                if (st.s2.csN || !st.s2.ds) begin
                    // Access withdrawn early: drop it unanswered
                    next_st.cpu = tss_pkg::CPU_IDLE;
                end else if (st.waitCnt != tss_pkg::WAIT_DONE) begin
                    next_st.waitCnt = 3'(st.waitCnt - 1'b1);
                end else begin
                    next_st.cpu = tss_pkg::CPU_ACK;
                    next_st.ackN = 1'b0;
                    next_st.doe = st.s2.rw;
                    if (!st.s2.addr[tss_pkg::ADDR_MEM_BIT]) begin
                        // Any address below 0x20 is the control register
                        if (st.s2.rw) begin
                            next_st.dout = st.ctrl & tss_pkg::CTRL_RD_MASK; // [RULE_05]
                        end else begin
                            next_st.ctrl = st.s2.din & tss_pkg::CTRL_RD_MASK; // [RULE_05]
                        end
                    end else if (st.s2.rw) begin
                        if (st.ctrl.split) begin
                            next_st.dout = st.dm[winIdx]; // [RULE_07]
                        end else begin
                            case (st.ctrl.memSel)
                                tss_pkg::MS_DATA: next_st.dout = st.dm[winIdx]; // [RULE_09]
                                tss_pkg::MS_CML: next_st.dout = st.cml[winIdx]; // [RULE_09]
                                tss_pkg::MS_CMH: next_st.dout = {5'h00, st.cmh[winIdx]}; // [RULE_09]
                                default: next_st.dout = 8'h00;
                            endcase
                        end
                    end else begin
                        // Data memory is read-only; reserved select ignores writes
                        if (st.ctrl.split || st.ctrl.memSel == tss_pkg::MS_CML) begin
                            next_st.cml[winIdx] = st.s2.din; // [RULE_07] [RULE_09]
                        end else if (st.ctrl.memSel == tss_pkg::MS_CMH) begin
                            next_st.cmh[winIdx] = st.s2.din[2:0]; // [RULE_09]
                        end
                    end
                end
            end
            tss_pkg::CPU_ACK: begin
                // Acknowledge holds until the processor ends the access
                if (st.s2.csN || !st.s2.ds) begin
                    next_st.cpu = tss_pkg::CPU_IDLE; // [RULE_19]
                    next_st.ackN = 1'b1;
                    next_st.doe = 1'b0;
                end
            end
            default: begin
                next_st.cpu = tss_pkg::CPU_IDLE;
                next_st.ackN = 1'b1;
                next_st.doe = 1'b0;
            end
        endcase

        // Synchronous reset: everything cleared, lines released
        if (!rst_n) begin
            next_st = '0;
            next_st.ctrl = tss_pkg::CTRL_RESET;
            next_st.ackN = 1'b1;
            next_st.cpu = tss_pkg::CPU_IDLE;
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        st <= next_st;
    end

    // Outputs straight from flip-flops
    assign serialOutLine = st.serOut;
    assign serialOutLineEn = st.serOutEn;
    assign controlStreamOut = st.cstOut;
    assign dataOut = st.dout;
    assign dataOe = st.doe;
    assign dataAcknowledgeN = st.ackN;

endmodule // tss_switch
`default_nettype wire

// >>> tss_switch_properties.sv
// Concurrent checks on the ports of the time-slot switch
`timescale 1ns/1ps
`default_nettype none
module tss_switch_properties (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Serial side
    input wire logic [7:0] serialOutLine,
    input wire logic [7:0] serialOutLineEn,
    input wire logic outputDriveEnable,
    // Processor port
    input wire logic chipSelectN,
    input wire logic readWrite,
    input wire logic dataStrobe,
    input wire logic [5:0] address,
    input wire logic dataOe,
    input wire logic dataAcknowledgeN
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // Drive enable pin low: no driver may stay on once the pin has settled
    ode_off_a: assert property (
        !outputDriveEnable [*4] |-> serialOutLineEn == 8'h00)
        else $error("drivers on while drive enable is low");
    // Outputs come out of reset quiet
    rst_quiet_a: assert property (
        $rose(rst_n) |-> dataAcknowledgeN && !dataOe && serialOutLineEn == 8'h00)
        else $error("outputs not quiet after reset");
    // Acknowledge only answers a request still being held
    ack_cause_a: assert property (
        $fell(dataAcknowledgeN) |-> $past(!chipSelectN) && $past(dataStrobe))
        else $error("acknowledge without a held request");
    // Sync takes two cycles, so release gets a margin of one
    ack_release_a: assert property (
        (chipSelectN || !dataStrobe) [*5] |-> dataAcknowledgeN)
        else $error("acknowledge held after request withdrawn");
    ctrl_fast_a: assert property (
        $rose(dataStrobe) && !chipSelectN && !readWrite && !address[5]
        |-> ##[3:5] $fell(dataAcknowledgeN))
        else $error("control write not answered fast");
    slow_access_a: assert property (
        $rose(dataStrobe) && !chipSelectN && (readWrite || address[5])
        |-> dataAcknowledgeN [*6] ##[1:4] !dataAcknowledgeN)
        else $error("slow access answered at the wrong time");
    read_drive_a: assert property (
        $rose(dataOe) |-> !dataAcknowledgeN && readWrite)
        else $error("data bus driven outside a read answer");
    // A bit cell lasts two link periods, far more than eight clocks
    out_cell_a: assert property (
        $changed(serialOutLine) |=> $stable(serialOutLine) [*8])
        else $error("serial output bit shorter than a cell");

    // Main scenarios
    cover property ($fell(dataAcknowledgeN) && dataOe);
    cover property (serialOutLineEn == 8'hFF);
    cover property (!outputDriveEnable [*4]);
endmodule // tss_switch_properties

bind tss_switch tss_switch_properties tss_switch_properties_i (
    .clk_sys, .rst_n, .serialOutLine, .serialOutLineEn, .outputDriveEnable,
    .chipSelectN, .readWrite, .dataStrobe, .address, .dataOe, .dataAcknowledgeN
);
`default_nettype wire

// >>> tss_link_model.sv
// Far-side stream partner: link timing, source bytes and output capture
`timescale 1ns/1ps
`default_nettype none
module tss_link_model (
    // Link timing
    output logic cN,
    output logic frameN,
    // Streams
    output logic [7:0] txLine,
    input wire logic [7:0] rxLine,
    input wire logic [7:0] rxEn,
    input wire logic cst,
    // Last captured frame
    output logic [7:0] gotByte [8][32],
    output logic gotEn [8][32],
    output logic [7:0] gotCst [32],
    output int frames
);
    int cnt = 0;
    logic [7:0] sh [8];
    logic [7:0] csh;
    logic [7:0] b;

    function automatic logic [7:0] srcByte(input int s, input int c);
        return 8'(c * 8 + s) ^ 8'h5A;
    endfunction

    // Streams never pause, so the link clock runs free
    initial begin
        cN = 1'b1;
        frameN = 1'b1;
        txLine = 8'h00;
        frames = 0;
    end
    always #80 cN = ~cN;

    // Link periods; 512 make one frame of 32 channels
    always @(posedge cN) begin
        cnt <= (cnt == 511) ? 0 : cnt + 1;
    end

    // Mid-period: launch on even counts, capture on odd ones, away from edges
    always @(negedge cN) begin
        frameN <= (cnt != 511);
        if (cnt == 511)
            frames <= frames + 1;
        csh <= cnt[0] ? {csh[6:0], cst} : csh;
        if (cnt[3:0] == 4'hF)
            gotCst[cnt / 16] <= {csh[6:0], cst};
        for (int s = 0; s < 8; s++) begin
            b = srcByte(s, cnt / 16);
            if (!cnt[0])
                txLine[s] <= b[7 - (cnt / 2) % 8];
            else
                sh[s] <= {sh[s][6:0], rxLine[s]};
            if (cnt[3:0] == 4'hF) begin
                gotByte[s][cnt / 16] <= {sh[s][6:0], rxLine[s]};
                gotEn[s][cnt / 16] <= rxEn[s];
            end
        end
    end
endmodule // tss_link_model
`default_nettype wire

// >>> tss_tb.sv
// Self-checking bench of the time-slot switch
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic csN = 1'b1, rw = 1'b1, ds = 1'b0, output_drive_enable = 1'b1;
    logic [5:0] addr = 6'h00;
    logic [7:0] din = 8'h00, dout, sOut, sEn, sIn, q;
    logic oe, ackN, cst, cN, frameN;
    logic [7:0] gotByte [8][32];
    logic gotEn [8][32];
    logic [7:0] gotCst [32];
    int frames, n, failures = 0, checks_done = 0;

    always #10 clk_sys = ~clk_sys;

    tss_switch tss_switch_i (.clk_sys(clk_sys), .rst_n(rst_n), .bitTimingClockInN(cN),
        .framePulseInN(frameN), .serialInLine(sIn), .serialOutLine(sOut),
        .serialOutLineEn(sEn), .outputDriveEnable(output_drive_enable), .controlStreamOut(cst),
        .chipSelectN(csN), .readWrite(rw), .dataStrobe(ds), .address(addr),
        .dataIn(din), .dataOut(dout), .dataOe(oe), .dataAcknowledgeN(ackN));
    tss_link_model tss_link_model_i (.cN(cN), .frameN(frameN), .txLine(sIn),
        .rxLine(sOut), .rxEn(sEn), .cst(cst), .gotByte(gotByte), .gotEn(gotEn),
        .gotCst(gotCst), .frames(frames));

    function automatic logic [7:0] srcByte(input int s, input int c);
        return 8'(c * 8 + s) ^ 8'h5A;
    endfunction

    task automatic close_out();
        $display("checks %0d, mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        checks_done++;
        if (seen !== want) begin
            failures++;
            $display("BAD at %0t: seen %h, expected %h", $time, seen, want);
        end
    endtask

    // One access, held until acknowledge; a hang ends the run
    task automatic acc(input logic r, input logic [5:0] a, input logic [7:0] d);
        int m;
        csN <= 1'b0;
        rw <= r;
        addr <= a;
        din <= d;
        ds <= 1'b1;
        n = 0;
        while (ackN !== 1'b0 && n < 40) begin
            @(posedge clk_sys);
            n++;
        end
        q = dout;
        csN <= 1'b1;
        ds <= 1'b0;
        m = 0;
        while (ackN !== 1'b1 && m < 40) begin
            @(posedge clk_sys);
            m++;
        end
        @(posedge clk_sys);
        if (n >= 40 || m >= 40) begin
            failures++;
            close_out();
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        acc(1'b0, a, d);
    endtask

    task automatic rd(input logic [5:0] a, input logic [7:0] want);
        acc(1'b1, a, 8'h00);
        check(q, want);
    endtask

    task automatic wait_frames(input int k);
        int f0, m;
        f0 = frames;
        m = 0;
        while (frames < f0 + k && m < k * 5000) begin
            @(posedge clk_sys);
            m++;
        end
        if (m >= k * 5000) begin
            failures++;
            close_out();
        end
    endtask

    // Low entry, then output channel control entry, of one output slot
    task automatic conn(input logic [2:0] os, input logic [4:0] oc, input logic [7:0] lo, hi);
        wr(6'h00, {5'b00010, os});
        wr({1'b1, oc}, lo);
        wr(6'h00, {5'b00011, os});
        wr({1'b1, oc}, hi);
        rd({1'b1, oc}, hi);
    endtask

    // Control register: any low address, bit 5 dropped, write faster than read
    task automatic t_ctrl();
        int nw;
        rd(6'h00, 8'h00);
        wr(6'h1F, 8'hBA);
        nw = n;
        rd(6'h07, 8'h9A);
        check(8'(nw < n), 8'h01);
        wr(6'h00, 8'h00);
    endtask

    // Data memory at stream/channel slots 0/0, 7/31 and 6/30; its writes refused; low entries start clear
    task automatic t_dmem();
        logic [2:0] s;
        logic [4:0] c;
        for (int i = 0; i < 3; i++) begin
            s = 3'(7 * i);
            c = 5'(31 * i);
            wr(6'h00, {5'b00001, s});
            rd({1'b1, c}, srcByte(s, c));
            wr(6'h25, 8'hFF);
            rd(6'h25, srcByte(s, 5));
            wr(6'h00, {5'b00010, s});
            rd(6'h2C, 8'h00);
        end
    endtask

    // Switched, message, disabled and control-stream slots, incl. wrap to channel 0
    task automatic t_switch();
        conn(3'h3, 5'h05, 8'hD4, 8'h01);
        conn(3'h0, 5'h1F, 8'hE0, 8'h03);
        conn(3'h5, 5'h09, 8'hC3, 8'h07);
        conn(3'h2, 5'h00, 8'h11, 8'h02);
        wait_frames(3);
        check(gotByte[3][5], srcByte(6, 20));
        check(gotByte[0][31], srcByte(7, 0));
        check(gotByte[5][9], 8'hC3);
        check({7'h00, gotEn[3][5]}, 8'h01);
        check({7'h00, gotEn[2][0]}, 8'h00);
        check(gotCst[30], 8'h80);
        check(gotCst[8], 8'h04);
        check(gotCst[31], 8'h20);
    endtask

    // Split mode: window reads data memory while writes land in the low entry
    task automatic t_split();
        wr(6'h00, 8'h8A);
        wr(6'h24, 8'h77);
        rd(6'h24, srcByte(2, 4));
        wr(6'h00, 8'h12);
        rd(6'h24, 8'h77);
    endtask

    // Broadcast: every slot sends its low entry and drives
    task automatic t_bcast();
        wr(6'h00, 8'h40);
        wait_frames(2);
        check(gotByte[3][5], 8'hD4);
        check(gotByte[2][4], 8'h77);
        check({7'h00, gotEn[2][0]}, 8'h01);
        check({7'h00, gotEn[1][1]}, 8'h01);
    endtask

    task automatic t_ode();
        output_drive_enable <= 1'b0;
        wait_frames(2);
        check({7'h00, gotEn[1][1]}, 8'h00);
        output_drive_enable <= 1'b1;
    endtask

    initial begin
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        wait_frames(2);
        t_ctrl();
        t_dmem();
        t_switch();
        t_split();
        t_bcast();
        t_ode();
        close_out();
    end
endmodule // tb
`default_nettype wire
